/* File: rtl/lpw_link_power.sv */
// Link power-sense monitor, interface state and link-wake generator
`timescale 1ns/1ps
module lpw_link_power #(
    parameter int WAKE_CNT = lpw_pkg::WAKE_CYCLES
) (
    input  wire logic                      ref_clk,
    input  wire logic                      reset_n,
    input  wire logic                      clk_en,
    input  wire logic                      link_power_sense,
    input  wire logic                      link_control_bit,
    input  wire logic                      port_change_irq_enable,
    input  wire logic                      link_request_in,
    input  wire lpw_pkg::lpw_event_type    events,
    input  wire lpw_pkg::lpw_link_out_type link_out_core,
    input  wire logic                      contender_wr,
    input  wire logic                      contender_wdata,
    input  wire logic                      power_class_pin_a,
    input  wire logic                      power_class_pin_b,
    input  wire logic                      power_class_pin_c,
    output lpw_pkg::lpw_link_out_type      link_out,
    output logic                           link_request_core,
    output logic                           phy_clk_enable,
    output logic                           repeater_enable,
    output logic                           bus_reset_req,
    output logic                           link_active,
    output logic                           link_wake_out,
    output logic                           contender,
    output logic [2:0]                     power_class,
    output lpw_pkg::lpw_state_type         if_state
);
    import lpw_pkg::*;

    localparam int WCW = $clog2(WAKE_CNT + 2);
    localparam int HCW = $clog2(WAKE_HALF_CYCLES + 1);

    ////////////////////////////////////////////////////////////////////////
    // Reset release and input synchronisers
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= 4'h0;
            pin_sync <= 4'h0;
        end else if (clk_en) begin
            pin_meta <= {power_class_pin_c, power_class_pin_b,
                         power_class_pin_a, link_power_sense};
            pin_sync <= pin_meta;
        end
    end
    wire sense_s = pin_sync[0];

    ////////////////////////////////////////////////////////////////////////
    // Low-time measurement and interface state
    logic over_reset;
    logic over_disable;
    lpw_low_timer u_timer (
        .ref_clk      (ref_clk),
        .rst_n        (rst_n),
        .clk_en       (clk_en),
        .sense        (sense_s),
        .over_reset   (over_reset),
        .over_disable (over_disable)
    );

    wire sense_active = !over_reset;

    lpw_state_type state;
    lpw_state_type next_state;
    always_comb begin
        next_state = state;
        case (state)
            LPW_ACTIVE: begin
                if (over_disable) next_state = LPW_DISABLED;
                else if (over_reset) next_state = LPW_RESET;
            end
            LPW_RESET: begin
                if (over_disable) next_state = LPW_DISABLED;
                else if (sense_active) next_state = LPW_ACTIVE;
            end
            LPW_DISABLED: begin
                if (sense_active) next_state = LPW_ACTIVE;
            end
            default: next_state = LPW_RESET;
        endcase
    end

    // Disabled state on the way out raises a one-cycle bus reset
    wire next_bus_reset = clk_en && (state == LPW_DISABLED) &&
                          sense_active;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state         <= LPW_RESET;
            bus_reset_req <= 1'b0;
        end else begin
            bus_reset_req <= next_bus_reset;
            if (clk_en) state <= next_state;
        end
    end
    assign if_state = state;

    wire if_up = (state == LPW_ACTIVE);
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            link_out <= '0;
        end else if (clk_en) begin
            link_out <= if_up ? link_out_core : '0;
        end
    end
    assign link_request_core = if_up & link_request_in;
    assign phy_clk_enable    = (state != LPW_DISABLED);
    assign repeater_enable   = 1'b1;
    assign link_active       = sense_active & link_control_bit;

    ////////////////////////////////////////////////////////////////////////
    // Configuration bits
    // Straps taken once the synchroniser holds a real pin sample
    logic [1:0] class_wait;
    wire        class_sample = (class_wait == 2'h2);
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            contender   <= CONTENDER_RST;
            power_class <= CLASS_RST;
            class_wait  <= 2'h0;
        end else if (clk_en) begin
            if (contender_wr) contender <= contender_wdata;
            if (class_wait != 2'h3) class_wait <= class_wait + 2'h1;
            if (class_sample) power_class <= pin_sync[3:1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link-wake request and square wave
    logic          wake_req;
    logic          irq_pend;
    logic          pwr_wake;
    logic [WCW-1:0] pwr_cnt;
    logic [HCW-1:0] half_cnt;

    wire irq_wake  = events.port_change & port_change_irq_enable &
                     !sense_active;
    wire pkt_wake  = events.link_on_pkt & !link_active;
    wire pwr_done  = (pwr_cnt == WCW'(WAKE_CNT));
    wire half_end  = (half_cnt == HCW'(WAKE_HALF_CYCLES - 1));
    wire wake_on   = wake_req | pwr_wake;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_req <= 1'b0;
            irq_pend <= 1'b0;
        end else if (clk_en) begin
            if (link_active) begin
                wake_req <= 1'b0;
                irq_pend <= 1'b0;
            end else if (pkt_wake || irq_wake) begin
                wake_req <= 1'b1;
                irq_pend <= irq_pend | irq_wake;
            end else if (events.bus_reset) begin
                wake_req <= irq_pend;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_wake <= 1'b0;
            pwr_cnt  <= '0;
        end else if (clk_en) begin
            if (events.power_up && power_class <= WAKE_MAX_CLASS) begin
                pwr_wake <= 1'b1;
                pwr_cnt  <= '0;
            end else if (pwr_wake) begin
                pwr_cnt <= pwr_cnt + WCW'(1);
                if (pwr_done || link_active) pwr_wake <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            half_cnt      <= '0;
            link_wake_out <= 1'b0;
        end else if (clk_en) begin
            if (!wake_on) begin
                half_cnt      <= '0;
                link_wake_out <= 1'b0;
            end else if (half_end) begin
                half_cnt      <= '0;
                link_wake_out <= !link_wake_out;
            end else begin
                half_cnt <= half_cnt + HCW'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    chk_reset_lines_zero: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        clk_en && state != LPW_ACTIVE |=> link_out == '0)
        else $error("link lines not zero outside active state");
    chk_request_ignored: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        state != LPW_ACTIVE |-> !link_request_core)
        else $error("link request passed while interface down");
    chk_clock_stopped: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        clk_en && over_disable |=> !phy_clk_enable)
        else $error("phy clock enable wrong for state");
    chk_disable_entry: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        clk_en && over_disable |=> state == LPW_DISABLED)
        else $error("disabled state not entered");
    chk_bus_reset_exit: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        clk_en && state == LPW_DISABLED && sense_active
        |=> bus_reset_req && state == LPW_ACTIVE)
        else $error("no bus reset on leaving disabled state");
    chk_link_active_and: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        link_active |-> sense_active && link_control_bit)
        else $error("link active without sense and control bit");
    chk_wake_square: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        clk_en && wake_on && half_end |=> $changed(link_wake_out))
        else $error("wake output did not toggle");
    chk_wake_stop: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        clk_en && link_active |=> !wake_req)
        else $error("wake kept after link became active");
    chk_wake_start: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        clk_en && pkt_wake |=> wake_req)
        else $error("wake not raised on link-on packet");
    chk_power_wake_len: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        pwr_wake && clk_en |-> pwr_cnt <= WCW'(WAKE_CNT))
        else $error("power-up wake overran its time");

    cov_disable_return: cover property (@(posedge ref_clk)
        disable iff (!rst_n) bus_reset_req);
    cov_wake_toggle: cover property (@(posedge ref_clk)
        disable iff (!rst_n) $rose(link_wake_out));
    cov_reset_state: cover property (@(posedge ref_clk)
        disable iff (!rst_n) state == LPW_RESET ##1 state == LPW_ACTIVE);
endmodule : lpw_link_power

/* File: include/lpw_pkg.sv */
// Package: constants and types for the link power and wake control block
package lpw_pkg;

    // Reference clock in kHz, 25 MHz
    localparam int CLK_KHZ           = 25000;
    // Times in nanoseconds as printed
    localparam int RESET_TIME_NS     = 2600;
    localparam int DISABLE_TIME_NS   = 26000;
    localparam int WAKE_TIME_NS      = 167000;
    // Longest times round down to whole cycles, with no lower limit of one cycle
    localparam int RESET_CYCLES      = (RESET_TIME_NS * (CLK_KHZ / 1000))
                                       / 1000;
    localparam int DISABLE_CYCLES    = (DISABLE_TIME_NS * (CLK_KHZ / 1000))
                                       / 1000;
    localparam int WAKE_CYCLES       = (WAKE_TIME_NS * (CLK_KHZ / 1000))
                                       / 1000;
    // Half period of the wake square wave, in cycles
    localparam int WAKE_HALF_CYCLES  = 4;
    // Highest power class that gets the power-up wake pulse
    localparam logic [2:0] WAKE_MAX_CLASS = 3'h4;
    // Width of the parallel data lines
    localparam int DATA_W            = 8;
    // Reset values
    localparam logic       CONTENDER_RST = 1'b0;
    localparam logic [2:0] CLASS_RST     = 3'h0;

    typedef enum logic [2:0] {
        LPW_ACTIVE   = 3'b001,
        LPW_RESET    = 3'b010,
        LPW_DISABLED = 3'b100
    } lpw_state_type;

    // Wake-up events from the packet and interrupt logic
    typedef struct packed {
        logic link_on_pkt;
        logic port_change;
        logic bus_reset;
        logic power_up;
    } lpw_event_type;

    // Interface outputs toward the link controller
    typedef struct packed {
        logic              ctl_a;
        logic              ctl_b;
        logic [DATA_W-1:0] data;
    } lpw_link_out_type;

endpackage : lpw_pkg

/* File: rtl/lpw_low_timer.sv */
// Low-time counter for the sampled link power-sense level
`timescale 1ns/1ps
module lpw_low_timer #(
    parameter int RESET_CNT   = lpw_pkg::RESET_CYCLES,
    parameter int DISABLE_CNT = lpw_pkg::DISABLE_CYCLES,
    parameter int CW          = $clog2(DISABLE_CNT + 2)
) (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic clk_en,
    input  wire logic sense,
    output logic      over_reset,
    output logic      over_disable
);
    import lpw_pkg::*;

    logic [CW-1:0] count;
    wire           at_top = (count == CW'(DISABLE_CNT + 1));

    // Restart on every high sample, saturate past the disable limit
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (clk_en) begin
            if (sense) begin
                count <= '0;
            end else if (!at_top) begin
                count <= count + CW'(1);
            end
        end
    end

    assign over_reset   = (count > CW'(RESET_CNT));
    assign over_disable = (count > CW'(DISABLE_CNT));

    chk_low_restart: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && sense |=> !over_reset)
        else $error("low timer not restarted by high sense");
endmodule : lpw_low_timer

/* File: tb/lpw_link_model.sv */
// Behavioural link controller that drives the power-sense pin
`timescale 1ns/1ps
module lpw_link_model (
    input  wire logic ref_clk,
    input  wire logic powered,
    input  wire logic pulsed,
    output logic      link_power_sense
);
    logic [3:0] phase;
    initial begin
        phase            = 4'h0;
        link_power_sense = 1'b1;
    end
    // Pulsed mode: 2 cycles high, 10 low, both phases well inside limits
    always @(negedge ref_clk) begin
        phase            <= (phase == 4'hB) ? 4'h0 : phase + 4'h1;
        link_power_sense <= powered && (!pulsed || phase < 4'h2);
    end
endmodule : lpw_link_model

/* File: tb/link_power_wake_control_test.sv */
// Self-checking bench for the link power and wake control block
`timescale 1ns/1ps
module link_power_wake_control_test;
    import lpw_pkg::*;
    logic             ref_clk;
    logic             reset_n;
    logic             en;
    logic             powered;
    logic             pulsed;
    logic             sense;
    logic             ctrl;
    logic             irq_en;
    logic             req;
    lpw_event_type    ev;
    lpw_link_out_type core;
    logic             cont_wr;
    logic             cont_wd;
    logic [2:0]       pins;
    lpw_link_out_type link_out;
    logic             link_request_core;
    logic             phy_clk_enable;
    logic             repeater_enable;
    logic             bus_reset_req;
    logic             link_active;
    logic             link_wake_out;
    logic             contender;
    logic [2:0]       power_class;
    lpw_state_type    if_state;
    int               mismatches = 0;
    int               tests_run = 0;
    int               r;
    logic             hit;

    lpw_link_model model (.ref_clk(ref_clk), .powered(powered),
        .pulsed(pulsed), .link_power_sense(sense));

    lpw_link_power #(.WAKE_CNT(20)) DUT (
        .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(en),
        .link_power_sense(sense), .link_control_bit(ctrl),
        .port_change_irq_enable(irq_en), .link_request_in(req),
        .events(ev), .link_out_core(core), .contender_wr(cont_wr),
        .contender_wdata(cont_wd), .power_class_pin_a(pins[0]),
        .power_class_pin_b(pins[1]), .power_class_pin_c(pins[2]),
        .link_out(link_out), .link_request_core(link_request_core),
        .phy_clk_enable(phy_clk_enable), .repeater_enable(repeater_enable),
        .bus_reset_req(bus_reset_req), .link_active(link_active),
        .link_wake_out(link_wake_out), .contender(contender),
        .power_class(power_class), .if_state(if_state));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [15:0] seen,
                         input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc

    // Event bits in order link_on_pkt, port_change, bus_reset, power_up
    task automatic pulse(input logic [3:0] e);
        ev = lpw_event_type'(e);
        cyc(1);
        ev = lpw_event_type'(4'h0);
    endtask : pulse

    task automatic rises(input int n, output int cnt);
        logic prev;
        prev = link_wake_out;
        cnt  = 0;
        repeat (n) begin
            @(negedge ref_clk);
            if (link_wake_out === 1'b1 && prev !== 1'b1) cnt++;
            prev = link_wake_out;
        end
    endtask : rises

    task automatic seen_reset(input int n, output logic h);
        h = 1'b0;
        repeat (n) begin
            @(negedge ref_clk);
            if (bus_reset_req === 1'b1) h = 1'b1;
        end
    endtask : seen_reset

    task automatic done(input string nm);
        $display("test %s finished", nm);
    endtask : done

    task automatic stop_test;
        $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    ////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        stop_test();
    end

    initial begin
        reset_n = 1'b0;
        en      = 1'b1;
        powered = 1'b1;
        pulsed  = 1'b0;
        ctrl    = 1'b0;
        irq_en  = 1'b1;
        req     = 1'b1;
        ev      = lpw_event_type'(4'h0);
        core    = lpw_link_out_type'(10'h2A5);
        cont_wr = 1'b0;
        cont_wd = 1'b0;
        pins    = 3'h3;
        cyc(16);
        reset_n = 1'b1;
        cyc(6);
        check("if_state", if_state, LPW_ACTIVE);
        check("power_class", power_class, 3'h3);
        check("contender", contender, 1'b0);
        check("repeater", repeater_enable, 1'b1);
        check("link_out", link_out, core);
        check("request", link_request_core, 1'b1);
        check("link_active", link_active, 1'b0);
        cont_wr = 1'b1;
        cont_wd = 1'b1;
        cyc(1);
        cont_wr = 1'b0;
        cyc(1);
        check("contender", contender, 1'b1);
        done("reset");
        pulsed = 1'b1;
        ctrl   = 1'b1;
        repeat (200) begin
            cyc(1);
            check("if_state", if_state, LPW_ACTIVE);
        end
        check("link_active", link_active, 1'b1);
        pulsed  = 1'b0;
        cyc(6);
        powered = 1'b0;
        cyc(60);
        check("if_state", if_state, LPW_ACTIVE);
        cyc(20);
        check("if_state", if_state, LPW_RESET);
        check("link_out", link_out, 10'h000);
        check("request", link_request_core, 1'b0);
        check("phy_clk", phy_clk_enable, 1'b1);
        check("link_active", link_active, 1'b0);
        cyc(560);
        check("if_state", if_state, LPW_RESET);
        cyc(30);
        check("if_state", if_state, LPW_DISABLED);
        check("phy_clk", phy_clk_enable, 1'b0);
        check("repeater", repeater_enable, 1'b1);
        done("power_down");
        pulse(4'h4);
        rises(20, r);
        check("irq_wake", r >= 2, 1'b1);
        check("wake_square", r <= 3, 1'b1);
        powered = 1'b1;
        seen_reset(12, hit);
        check("bus_reset", hit, 1'b1);
        check("if_state", if_state, LPW_ACTIVE);
        cyc(3);
        rises(10, r);
        check("wake_stop", r, 0);
        check("wake_level", link_wake_out, 1'b0);
        powered = 1'b0;
        cyc(100);
        powered = 1'b1;
        seen_reset(12, hit);
        check("bus_reset", hit, 1'b0);
        done("power_return");
        pulse(4'h8);
        rises(20, r);
        check("active_wake", r, 0);
        ctrl = 1'b0;
        cyc(1);
        check("link_active", link_active, 1'b0);
        pulse(4'h8);
        rises(20, r);
        check("lkon_wake", r >= 2, 1'b1);
        check("if_state", if_state, LPW_ACTIVE);
        pulse(4'h2);
        cyc(3);
        rises(12, r);
        check("bus_reset_clear", r, 0);
        done("link_on");
        pulse(4'h1);
        rises(20, r);
        check("powerup_wake", r >= 2, 1'b1);
        cyc(30);
        rises(16, r);
        check("powerup_end", r, 0);
        done("power_up");
        powered = 1'b0;
        cyc(80);
        irq_en = 1'b0;
        pulse(4'h4);
        rises(12, r);
        check("irq_masked", r, 0);
        irq_en = 1'b1;
        pulse(4'h4);
        cyc(2);
        pulse(4'h2);
        rises(20, r);
        check("irq_pending", r >= 2, 1'b1);
        en  = 1'b0;
        hit = link_wake_out;
        cyc(10);
        check("frozen_wake", link_wake_out, hit);
        en  = 1'b1;
        done("irq_pending");
        powered = 1'b1;
        pins    = 3'h5;
        reset_n = 1'b0;
        cyc(2);
        reset_n = 1'b1;
        cyc(8);
        check("power_class", power_class, 3'h5);
        pulse(4'h1);
        rises(20, r);
        check("class_no_wake", r, 0);
        done("class_five");
        stop_test();
    end
endmodule : link_power_wake_control_test
